// File: line_delay_pkg.sv
package line_delay_pkg;

  // Storage geometry.
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int PTR_W = 14;
  localparam int INDEX_W = 13;
  localparam int FIFO_DEPTH = 32;
  localparam logic [PTR_W-1:0] WORD_DEPTH = 14'h13b8;
  localparam logic [PTR_W-1:0] BYTE_DEPTH = 14'h2770;
  localparam logic [PTR_W-1:0] WORD_LAST = 14'h13b7;
  localparam logic [PTR_W-1:0] BYTE_LAST = 14'h276f;
  localparam logic [PTR_W-1:0] PTR_ZERO = 14'h0000;

  // Organisation select levels.
  localparam logic MODE_WORD = 1'b0;
  localparam logic MODE_BYTE = 1'b1;

  // Reset value of the data output register.
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [LANE_W-1:0] LANE_ZERO = 8'h00;

  // Write-side pins, carried together through the synchroniser.
  typedef struct packed {
    logic strobe;
    logic enable_n;
    logic clear_n;
    logic select;
    logic [DATA_W-1:0] data;
  } write_pins_s;

  // Read-side pins, carried together through the synchroniser.
  typedef struct packed {
    logic strobe;
    logic fetch_n;
    logic drive_n;
    logic clear_n;
    logic select;
  } read_pins_s;

  // One queued store into the line memory.
  typedef struct packed {
    logic byte_mode;
    logic [PTR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } write_entry_s;

  localparam int ENTRY_W = $bits(write_entry_s);

  localparam write_pins_s WRITE_PINS_IDLE = '{
    strobe: 1'b0, enable_n: 1'b1, clear_n: 1'b1, select: 1'b0,
    data: 16'h0000};
  localparam read_pins_s READ_PINS_IDLE = '{
    strobe: 1'b0, fetch_n: 1'b1, drive_n: 1'b1, clear_n: 1'b1,
    select: 1'b0};

endpackage

// File: stream_fifo.sv
module stream_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [$clog2(DEPTH):0] level_o
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  generate
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad
      $error("stream_fifo needs DEPTH of two or more and WIDTH of one or more");
    end
  endgenerate

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] head;
  logic [AW-1:0] tail;
  logic [AW:0] count;
  wire logic push;
  wire logic pop;

  function automatic logic [AW-1:0] advance(input logic [AW-1:0] p);
    advance = (p == LAST) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready_o = (count != FULL);
  assign out_valid_o = (count != '0);
  assign out_data_o = store[tail];
  assign level_o = count;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      store[head] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      head <= '0;
      tail <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        head <= advance(head);
      end
      if (pop)
      begin
        tail <= advance(tail);
      end
      if (push && !pop)
      begin
        count <= (AW+1)'(count + 1'b1);
      end
      else if (pop && !push)
      begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end

endmodule

// File: dual_clock_line_delay_fifo.sv
// Function
// R1 - Select pin chooses 16-bit or 8-bit organisation.
// R2 - Organisation latched only during a pointer clear.
// R3 - Driver holds select stable through the clear.
// R4 - Producer fixes upper input bits in byte mode.
// R5 - Write enabled: store word, advance write pointer.
// R6 - Write disabled: no store, pointer holds.
// R7 - Input data captured on the closing strobe edge; the code captures it on the rising strobe edge.
// R8 - Fetch enabled: read word, advance read pointer.
// R9 - Fetch disabled: pointer holds, outputs stay valid.
// R10 - Drive disabled: bus released, reads still continue.
// R11 - Bus driven only with fetch and drive enabled.
// R12 - Write pointer wraps from last word to zero.
// R13 - Read pointer wraps from last word to zero.
// R14 - Delay set by enables or clears, 21 upward.
// R15 - Close chase may return previous-line data.
// R16 - Controller clears both pointers after power-up.
// R17 - Write clear sampled on write strobe, zeroes pointer.
// R18 - Read clear sampled on read strobe, zeroes pointer.
// R19 - Clears act regardless of any enable.
// R20 - Reader waits half cycle plus 500 ns.
// R21 - Write and read ports run independently.
// R22 - Byte organisation wraps pointers at full depth.
// R23 - Select presented together with the clear.
// R24 - Held clear keeps pointer at zero each edge.
module dual_clock_line_delay_fifo #(
  parameter int BUFFER_DEPTH = line_delay_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Write port pins
  input wire logic write_strobe_clock_i,
  input wire logic write_enable_n_i,
  input wire logic write_pointer_clear_n_i,
  input wire logic [line_delay_pkg::DATA_W-1:0] input_data_bus_i,
  // Organisation strap
  input wire logic organization_select_i,
  // Read port pins
  input wire logic read_strobe_clock_i,
  input wire logic fetch_enable_n_i,
  input wire logic drive_enable_n_i,
  input wire logic read_pointer_clear_n_i,
  // Output bus, low and high byte enables
  output logic [line_delay_pkg::DATA_W-1:0] output_data_bus_o,
  output logic [1:0] output_data_bus_oe_o,
  // Status
  output logic byte_mode_o,
  output logic write_overrun_o
);

  generate
    if (BUFFER_DEPTH < 2)
    begin : g_bad
      $error("BUFFER_DEPTH must be two or more");
    end
  endgenerate

  localparam int LW = line_delay_pkg::LANE_W;
  localparam int DW = line_delay_pkg::DATA_W;
  localparam int PW = line_delay_pkg::PTR_W;
  localparam int IW = line_delay_pkg::INDEX_W;

  // The two-lane memory and the pointers are sized from the package.
  generate
    if (DW != 2 * LW)
    begin : g_bad_lanes
      $error("data width must be exactly two byte lanes");
    end
    if ((1 << IW) < int'(line_delay_pkg::WORD_DEPTH))
    begin : g_bad_rows
      $error("index width too small to hold a full line");
    end
    if ((1 << PW) <= int'(line_delay_pkg::BYTE_LAST))
    begin : g_bad_ptr
      $error("pointer width too small for the byte organisation");
    end
  endgenerate

  // Pointer step with the organisation-dependent wrap point.
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p,
                                             input logic byte_mode);
    logic [PW-1:0] last;
    last = byte_mode ? line_delay_pkg::BYTE_LAST : line_delay_pkg::WORD_LAST;
    next_ptr = (p == last) ? line_delay_pkg::PTR_ZERO : PW'(p + 1'b1);
  endfunction

  // Row of the two byte lanes that holds a pointer's entry.
  function automatic logic [IW-1:0] mem_index(input logic [PW-1:0] p,
                                              input logic byte_mode);
    mem_index = byte_mode ? p[PW-1:1] : p[IW-1:0];
  endfunction

  // Pin synchronisers; the meta stage feeds only the sync stage.
  // All pins of a port share one chain, so a strobe edge and the levels
  // that qualify it arrive together; each pin must hold three cycles.
  line_delay_pkg::write_pins_s wr_meta;
  line_delay_pkg::write_pins_s wr_sync;
  line_delay_pkg::read_pins_s rd_meta;
  line_delay_pkg::read_pins_s rd_sync;
  logic wr_last_strobe;
  logic rd_last_strobe;
  wire line_delay_pkg::write_pins_s wr_pins;
  wire line_delay_pkg::read_pins_s rd_pins;

  assign wr_pins = '{strobe: write_strobe_clock_i,
                     enable_n: write_enable_n_i,
                     clear_n: write_pointer_clear_n_i,
                     select: organization_select_i,
                     data: input_data_bus_i};
  assign rd_pins = '{strobe: read_strobe_clock_i,
                     fetch_n: fetch_enable_n_i,
                     drive_n: drive_enable_n_i,
                     clear_n: read_pointer_clear_n_i,
                     select: organization_select_i};

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_meta <= line_delay_pkg::WRITE_PINS_IDLE;
      wr_sync <= line_delay_pkg::WRITE_PINS_IDLE;
      wr_last_strobe <= line_delay_pkg::WRITE_PINS_IDLE.strobe;
    end
    else
    begin
      wr_meta <= wr_pins;
      wr_sync <= wr_meta;
      wr_last_strobe <= wr_sync.strobe;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_meta <= line_delay_pkg::READ_PINS_IDLE;
      rd_sync <= line_delay_pkg::READ_PINS_IDLE;
      rd_last_strobe <= line_delay_pkg::READ_PINS_IDLE.strobe;
    end
    else
    begin
      rd_meta <= rd_pins;
      rd_sync <= rd_meta;
      rd_last_strobe <= rd_sync.strobe;
    end
  end

  // Apart from the drive enable, each port acts only on a rising edge of its own strobe.
  wire logic wr_edge; // [R21]
  wire logic rd_edge; // [R21]
  assign wr_edge = wr_sync.strobe & ~wr_last_strobe;
  assign rd_edge = rd_sync.strobe & ~rd_last_strobe;

  wire logic wr_clear;
  wire logic rd_clear;
  wire logic wr_store;
  wire logic rd_fetch;
  assign wr_clear = wr_edge & ~wr_sync.clear_n; // [R17] [R19]
  assign rd_clear = rd_edge & ~rd_sync.clear_n; // [R18] [R19]
  assign wr_store = wr_edge & wr_sync.clear_n & ~wr_sync.enable_n; // [R5] [R6]
  assign rd_fetch = rd_edge & rd_sync.clear_n & ~rd_sync.fetch_n; // [R8] [R9]

  // Organisation register, loaded only by a clearing edge.
  logic byte_mode;
  wire logic next_byte_mode;
  assign next_byte_mode = wr_clear ? wr_sync.select :
                          rd_clear ? rd_sync.select : byte_mode; // [R2]

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      byte_mode <= line_delay_pkg::MODE_WORD;
    end
    else
    begin
      byte_mode <= next_byte_mode; // [R1] [R2]
    end
  end

  // Write pointer. Both pointers start at zero here, but the controller
  // must still clear them before it trusts the buffer.
  logic [PW-1:0] wr_ptr;
  wire logic [PW-1:0] next_wr_ptr;
  assign next_wr_ptr = wr_clear ? line_delay_pkg::PTR_ZERO : // [R14] [R24]
                       wr_store ? next_ptr(wr_ptr, byte_mode) : // [R12] [R22]
                       wr_ptr; // [R6]

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= line_delay_pkg::PTR_ZERO;
    end
    else
    begin
      wr_ptr <= next_wr_ptr; // [R5] [R17]
    end
  end

  // Stores queue up so a memory cycle lost to a fetch is not a lost word.
  wire line_delay_pkg::write_entry_s push_entry;
  wire line_delay_pkg::write_entry_s pop_entry;
  wire logic [line_delay_pkg::ENTRY_W-1:0] pop_bits;
  wire logic push_ready;
  wire logic pop_valid;
  wire logic pop_ready;
  assign push_entry = '{byte_mode: byte_mode, addr: wr_ptr,
                        data: wr_sync.data}; // [R7]
  assign pop_entry = line_delay_pkg::write_entry_s'(pop_bits);
  assign pop_ready = ~rd_fetch;

  stream_fifo #(
    .WIDTH(line_delay_pkg::ENTRY_W),
    .DEPTH(BUFFER_DEPTH)
  ) u_store_queue (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(wr_store),
    .in_ready_o(push_ready),
    .in_data_i(push_entry),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_bits),
    .level_o()
  );

  // A store that finds the queue full is dropped and flagged.
  // At legal strobe rates the queue drains faster than it fills, so the
  // flag only rises when a strobe runs faster than six system clocks.
  logic overrun;
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      overrun <= 1'b0;
    end
    else if (wr_store && !push_ready)
    begin
      overrun <= 1'b1;
    end
    else if (wr_clear)
    begin
      overrun <= 1'b0;
    end
  end

  // Line memory as two byte lanes so byte mode needs no read-modify-write.
  logic [LW-1:0] lane_lo [1 << IW];
  logic [LW-1:0] lane_hi [1 << IW];
  wire logic mem_write;
  wire logic [IW-1:0] wr_index;
  wire logic wr_lo;
  wire logic wr_hi;
  wire logic [LW-1:0] wr_hi_data;
  assign mem_write = pop_valid & pop_ready;
  assign wr_index = mem_index(pop_entry.addr, pop_entry.byte_mode);
  assign wr_lo = mem_write & (~pop_entry.byte_mode | ~pop_entry.addr[0]);
  assign wr_hi = mem_write & (~pop_entry.byte_mode | pop_entry.addr[0]);
  assign wr_hi_data = pop_entry.byte_mode ? pop_entry.data[LW-1:0] :
                      pop_entry.data[DW-1:LW]; // [R4]

  always_ff @(posedge clk_i)
  begin
    if (wr_lo)
    begin
      lane_lo[wr_index] <= pop_entry.data[LW-1:0];
    end
    if (wr_hi)
    begin
      lane_hi[wr_index] <= wr_hi_data;
    end
  end

  // Read pointer.
  logic [PW-1:0] rd_ptr;
  wire logic [PW-1:0] next_rd_ptr;
  assign next_rd_ptr = rd_clear ? line_delay_pkg::PTR_ZERO : // [R24]
                       rd_fetch ? next_ptr(rd_ptr, byte_mode) : // [R13] [R22]
                       rd_ptr; // [R9]

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_ptr <= line_delay_pkg::PTR_ZERO;
    end
    else
    begin
      rd_ptr <= next_rd_ptr; // [R8] [R18]
    end
  end

  // Queued stores not yet written make a close chase return old data.
  wire logic [IW-1:0] rd_index;
  wire logic [LW-1:0] rd_lo;
  wire logic [LW-1:0] rd_hi;
  wire logic [DW-1:0] fetched;
  assign rd_index = mem_index(rd_ptr, byte_mode);
  assign rd_lo = lane_lo[rd_index];
  assign rd_hi = lane_hi[rd_index];
  assign fetched = !byte_mode ? {rd_hi, rd_lo} :
                   rd_ptr[0] ? {line_delay_pkg::LANE_ZERO, rd_hi} :
                   {line_delay_pkg::LANE_ZERO, rd_lo}; // [R1] [R15]

  // Output data and drive enables.
  // Read data follows the strobe pin by two to three system clocks, the
  // price of synchronising the pins instead of clocking on the strobe.
  logic [DW-1:0] out_data;
  logic driving;
  wire logic next_driving;
  assign next_driving = rd_sync.drive_n ? 1'b0 : // [R10]
                        (rd_fetch & ~rd_sync.drive_n) ? 1'b1 : // [R11]
                        driving;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      driving <= 1'b0;
    end
    else
    begin
      driving <= next_driving; // [R10] [R11]
    end
  end

  // The register keeps its word between fetches, so the bus stays valid.
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      out_data <= line_delay_pkg::DATA_RESET;
    end
    else if (rd_fetch)
    begin
      out_data <= fetched; // [R8] [R9] [R10]
    end
  end

  assign output_data_bus_o = out_data;
  assign output_data_bus_oe_o = {driving & ~byte_mode, driving}; // [R1]
  assign byte_mode_o = byte_mode;
  assign write_overrun_o = overrun;

endmodule

// File: line_delay_sva.sv
module line_delay_sva #(
  parameter int BUFFER_DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Watched pins
  input wire logic write_pointer_clear_n_i,
  input wire logic read_pointer_clear_n_i,
  input wire logic organization_select_i,
  input wire logic fetch_enable_n_i,
  input wire logic drive_enable_n_i,
  // Watched outputs
  input wire logic [line_delay_pkg::DATA_W-1:0] output_data_bus_o,
  input wire logic [1:0] output_data_bus_oe_o,
  input wire logic byte_mode_o,
  input wire logic write_overrun_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // Cycles since either clear pin was last seen low, saturating.
  logic [3:0] clr_age;
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      clr_age <= 4'hf;
    else if (!write_pointer_clear_n_i || !read_pointer_clear_n_i)
      clr_age <= 4'h0;
    else if (clr_age != 4'hf)
      clr_age <= clr_age + 4'h1;

  sequence s_drive_off;
    drive_enable_n_i [*4];
  endsequence
  sequence s_idle_hold;
    (!drive_enable_n_i && fetch_enable_n_i) [*4];
  endsequence

  property p_byte_lanes;
    byte_mode_o |-> output_data_bus_o[15:8] == 8'h00 &&
      !output_data_bus_oe_o[1];
  endproperty
  a_byte_lanes: assert property (p_byte_lanes)
    else $error("upper lane active in byte organisation");
  property p_oe_off;
    s_drive_off |=> output_data_bus_oe_o == 2'b00;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("bus still driven with drive disabled");
  property p_oe_hold;
    s_idle_hold |=> $stable(output_data_bus_oe_o);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("drive changed while fetch disabled");
  property p_oe_rise;
    $rose(output_data_bus_oe_o[0]) |-> !$past(fetch_enable_n_i, 3) &&
      !$past(drive_enable_n_i, 3);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("bus driven without fetch and drive");
  property p_data_fetch;
    $changed(output_data_bus_o) |-> !$past(fetch_enable_n_i, 3);
  endproperty
  a_data_fetch: assert property (p_data_fetch)
    else $error("output data changed without a fetch");
  property p_mode_clear;
    $changed(byte_mode_o) |-> clr_age < 4'h5;
  endproperty
  a_mode_clear: assert property (p_mode_clear)
    else $error("organisation changed outside a clear");
  property p_mode_source;
    $changed(byte_mode_o) |-> byte_mode_o == $past(organization_select_i, 3);
  endproperty
  a_mode_source: assert property (p_mode_source)
    else $error("organisation differs from select pin");
  property p_overrun_clear;
    $fell(write_overrun_o) |-> !$past(write_pointer_clear_n_i, 3);
  endproperty
  a_overrun_clear: assert property (p_overrun_clear)
    else $error("overrun flag dropped without write clear");
endmodule

bind dual_clock_line_delay_fifo line_delay_sva #(
  .BUFFER_DEPTH(BUFFER_DEPTH)
) chk (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .write_pointer_clear_n_i(write_pointer_clear_n_i),
  .read_pointer_clear_n_i(read_pointer_clear_n_i),
  .organization_select_i(organization_select_i),
  .fetch_enable_n_i(fetch_enable_n_i),
  .drive_enable_n_i(drive_enable_n_i),
  .output_data_bus_o(output_data_bus_o),
  .output_data_bus_oe_o(output_data_bus_oe_o),
  .byte_mode_o(byte_mode_o),
  .write_overrun_o(write_overrun_o)
);

// File: line_pins_model.sv
module line_pins_model (
  // Clock
  input wire logic clk_i,
  // Producer pins
  output logic wr_strobe_o,
  output logic wr_en_n_o,
  output logic wr_clr_n_o,
  output logic [15:0] wr_data_o,
  output logic org_sel_o,
  // Consumer pins
  output logic rd_strobe_o,
  output logic fetch_n_o,
  output logic drive_n_o,
  output logic rd_clr_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {wr_strobe_o, rd_strobe_o, org_sel_o} = 3'h0;
    {wr_en_n_o, wr_clr_n_o, fetch_n_o, drive_n_o, rd_clr_n_o} = 5'h1f;
    wr_data_o = 16'h0000;
  end

  // Pins are set before the strobe rises and held until it falls, so the
  // synchroniser sees them steady on both sides of the rising edge.
  task automatic strobe(input logic rd);
    repeat (3) @(negedge clk_i);
    if (rd)
      rd_strobe_o = 1'b1;
    else
      wr_strobe_o = 1'b1;
    repeat (4) @(negedge clk_i);
    rd_strobe_o = 1'b0;
    wr_strobe_o = 1'b0;
  endtask

  task automatic wr(input logic [15:0] d, input logic en_n,
                    input logic clr_n, input logic sel);
    wr_data_o = d;
    wr_en_n_o = en_n;
    wr_clr_n_o = clr_n;
    org_sel_o = sel;
    strobe(1'b0);
  endtask

  task automatic rd(input logic f_n, input logic dr_n,
                    input logic clr_n, input logic sel);
    fetch_n_o = f_n;
    drive_n_o = dr_n;
    rd_clr_n_o = clr_n;
    org_sel_o = sel;
    strobe(1'b1);
  endtask
endmodule

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic reset_i;
  logic wr_strobe, wr_en_n, wr_clr_n, org_sel;
  logic rd_strobe, fetch_n, drive_n, rd_clr_n;
  logic [15:0] wr_data;
  logic [15:0] out_data;
  logic [1:0] out_oe;
  logic byte_mode;
  logic overrun;
  int fail_count = 0;
  int num_checks = 0;

  line_pins_model m (.clk_i(clk_i), .wr_strobe_o(wr_strobe),
    .wr_en_n_o(wr_en_n), .wr_clr_n_o(wr_clr_n), .wr_data_o(wr_data),
    .org_sel_o(org_sel), .rd_strobe_o(rd_strobe), .fetch_n_o(fetch_n),
    .drive_n_o(drive_n), .rd_clr_n_o(rd_clr_n));

  dual_clock_line_delay_fifo #(.BUFFER_DEPTH(4)) dut (.clk_i(clk_i),
    .reset_i(reset_i), .write_strobe_clock_i(wr_strobe),
    .write_enable_n_i(wr_en_n), .write_pointer_clear_n_i(wr_clr_n),
    .input_data_bus_i(wr_data), .organization_select_i(org_sel),
    .read_strobe_clock_i(rd_strobe), .fetch_enable_n_i(fetch_n),
    .drive_enable_n_i(drive_n), .read_pointer_clear_n_i(rd_clr_n),
    .output_data_bus_o(out_data), .output_data_bus_oe_o(out_oe),
    .byte_mode_o(byte_mode), .write_overrun_o(overrun));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Stored words must settle before the reader reaches them.
  task automatic settle();
    repeat (60) @(negedge clk_i);
  endtask

  task automatic t_byte();
    m.rd(1'b1, 1'b1, 1'b0, 1'b1);
    m.wr(16'h0000, 1'b0, 1'b0, 1'b1);
    check("byte mode", 16'h0001, {15'h0, byte_mode});
    for (int i = 0; i < 3; i++)
      m.wr({8'hff, 8'h30 + 8'(i)}, 1'b0, 1'b1, 1'b1);
    settle();
    for (int i = 0; i < 3; i++)
    begin
      m.rd(1'b0, 1'b0, 1'b1, 1'b1);
      check("byte data", {8'h00, 8'h30 + 8'(i)}, out_data);
      check("byte oe", 16'h0001, {14'h0, out_oe});
    end
    $display("t_byte done");
  endtask

  task automatic t_mode_latch();
    m.wr(16'hffaa, 1'b1, 1'b1, 1'b0);
    check("mode kept", 16'h0001, {15'h0, byte_mode});
    m.wr(16'hff44, 1'b0, 1'b1, 1'b1);
    settle();
    m.rd(1'b0, 1'b0, 1'b1, 1'b1);
    check("no store", 16'h0044, out_data);
    $display("t_mode_latch done");
  endtask

  task automatic t_word();
    m.rd(1'b1, 1'b1, 1'b0, 1'b0);
    m.wr(16'h0000, 1'b1, 1'b0, 1'b0);
    check("word mode", 16'h0000, {15'h0, byte_mode});
    for (int i = 0; i < 4; i++)
      m.wr(16'ha5c0 + 16'(i), 1'b0, 1'b1, 1'b0);
    settle();
    for (int i = 0; i < 2; i++)
    begin
      m.rd(1'b0, 1'b0, 1'b1, 1'b0);
      check("word data", 16'ha5c0 + 16'(i), out_data);
    end
    check("word oe", 16'h0003, {14'h0, out_oe});
    m.rd(1'b1, 1'b0, 1'b1, 1'b0);
    check("held data", 16'ha5c1, out_data);
    check("held oe", 16'h0003, {14'h0, out_oe});
    m.rd(1'b0, 1'b1, 1'b1, 1'b0);
    check("released oe", 16'h0000, {14'h0, out_oe});
    m.rd(1'b0, 1'b0, 1'b1, 1'b0);
    check("skipped word", 16'ha5c3, out_data);
    check("overrun", 16'h0000, {15'h0, overrun});
    $display("t_word done");
  endtask

  task automatic t_clears();
    m.rd(1'b1, 1'b1, 1'b0, 1'b0);
    m.rd(1'b1, 1'b1, 1'b0, 1'b0);
    m.rd(1'b0, 1'b0, 1'b1, 1'b0);
    check("read clear", 16'ha5c0, out_data);
    m.wr(16'h0000, 1'b1, 1'b0, 1'b0);
    m.wr(16'h7e01, 1'b0, 1'b1, 1'b0);
    settle();
    m.rd(1'b1, 1'b1, 1'b0, 1'b0);
    m.rd(1'b0, 1'b0, 1'b1, 1'b0);
    check("write clear", 16'h7e01, out_data);
    $display("t_clears done");
  endtask

  // One word past a full line lands on location zero again.
  task automatic t_wrap();
    m.wr(16'h0000, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i <= 5048; i++)
      m.wr(16'(i), 1'b0, 1'b1, 1'b0);
    settle();
    m.rd(1'b1, 1'b1, 1'b0, 1'b0);
    m.rd(1'b0, 1'b0, 1'b1, 1'b0);
    check("write wrap", 16'h13b8, out_data);
    repeat (5047) m.rd(1'b0, 1'b0, 1'b1, 1'b0);
    check("last word", 16'h13b7, out_data);
    m.rd(1'b0, 1'b0, 1'b1, 1'b0);
    check("read wrap", 16'h13b8, out_data);
    $display("t_wrap done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    reset_i = 1'b1;
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    t_byte();
    t_mode_latch();
    t_word();
    t_clears();
    t_wrap();
    finish_test();
  end
endmodule
